// file: verilog/usrx_receiver.sv
// Purpose: serial port receive path, async and synchronous master, avalon-mm slave
// Assumes: pin inputs synchronous to i_clk; 50 MHz clock
// Notes:   two deep receive fifo carries ninth bit and framing flag
// Behaviour
// (RULE1) synchronous mode starts receiving when single or continuous enable set
// (RULE2) synchronous master samples data pin at falling serial clock edge
// (RULE3) single enable receives exactly one word then stops
// (RULE4) continuous enable keeps receiving until software clears it
// (RULE5) both enables set behaves as continuous reception
// (RULE6) finished word moves from shift register into fifo if room
// (RULE7) word moved into fifo sets receive complete flag
// (RULE8) interrupt request only while receive interrupt enable set
// (RULE9) complete flag read only; cleared when fifo emptied by reads
// (RULE10) receive data is two entry fifo; third word may shift meanwhile
// (RULE11) fifo full at last bit sets overrun and drops word
// (RULE12) overrun set blocks every move into fifo
// (RULE13) clearing continuous enable clears overrun flag
// (RULE14) ninth bit and framing flag queued per word; data read advances
// (RULE15) clearing both enables or port enable resets receive logic
// (RULE16) software selects async by clearing mode bit, sets port enable
// (RULE17) async receiver accepts characters only after continuous enable set
// (RULE18) nine bit enable captures ninth bit into status field
// (RULE19) software sets mode, port enable, clock source for sync master
// (RULE20) framing error reported per word in status bit
// (RULE21) bit rate comes from baud divisor register
// (RULE22) receive status bit 3 always reads zero
// (RULE23) async: start detect, lsb first 8 or 9 bits, low stop flags
// (RULE24) sync master drives clock from divisor, stops after single word
//
// The Avalon-MM register port is this design's own decision.
`timescale 1ns/1ps
`include "usrx_defines.svh"
module usrx_receiver
(
   input  wire logic               i_clk,
   input  wire logic               i_resetn,
   input  wire logic [6:0]         i_avs_address,
   input  wire logic               i_avs_read,
   input  wire logic               i_avs_write,
   input  wire logic [31:0]        i_avs_writedata,
   input  wire logic [3:0]         i_avs_byteenable,
   output logic      [31:0]        o_avs_readdata,
   output logic                    o_avs_waitrequest,
   output logic      [1:0]         o_avs_response,
   input  wire logic               i_rx_pin,
   output logic                    o_rx_pin_out,
   output logic                    o_rx_pin_oen,
   output logic                    o_sclk,
   output logic                    o_sclk_oen,
   output logic                    o_irq
);
   import usrx_pkg::*;

   typedef struct packed {
      logic [7:0]  rcv_ctl;     // serial_port_enable, nine, single_receive_enable, continuous_receive_enable
      logic        overrun_error_flag;
      logic        clock_source_master;
      logic        sync;
      logic [7:0]  baud;
      logic        receive_interrupt_enable;
      usrx_word_t  fifo0;
      usrx_word_t  fifo1;
      logic [1:0]  count;
      usrx_state_e st;
      logic [7:0]  brg;
      logic [3:0]  ovs;
      logic [3:0]  bitn;
      logic [8:0]  shift;
      logic        sclk;
      logic        ack;
      logic [31:0] rdata;
      logic [1:0]  resp;
      logic        irq;
   } usrx_regs_s;

   usrx_regs_s r_q;
   usrx_regs_s r_d;

   // one sixteenth bit period tick or half period in sync mode
   function automatic logic brg_tick(input logic [7:0] cnt);
      brg_tick = (cnt == 8'h00);
   endfunction : brg_tick

   logic       serial_port_enable;
   logic       single_receive_enable;
   logic       continuous_receive_enable;
   logic       nine;
   logic       tick;
   logic       active;
   logic [3:0] last_bit;
   logic       word_end;
   logic       word_framing_error_flag;
   logic       access;
   logic       do_read;
   logic       do_write;
   logic [4:0] idx;
   logic       map_hit;
   logic [7:0] rd_byte;

   assign serial_port_enable     = r_q.rcv_ctl[`USRX_BIT_SERIAL_PORT_ENABLE];
   assign single_receive_enable     = r_q.rcv_ctl[`USRX_BIT_SINGLE_RECEIVE_ENABLE];
   assign continuous_receive_enable     = r_q.rcv_ctl[`USRX_BIT_CONTINUOUS_RECEIVE_ENABLE];
   assign nine     = r_q.rcv_ctl[`USRX_BIT_NINE];
   assign tick     = brg_tick(r_q.brg);
   assign last_bit = nine ? `USRX_DATA_LAST9 : `USRX_DATA_LAST8;
   // async waits for continuous enable, sync for either enable
   assign active   = serial_port_enable && (r_q.sync ? (single_receive_enable || continuous_receive_enable) : continuous_receive_enable); // [RULE1] [RULE17] [RULE15]
   assign access   = (i_avs_read || i_avs_write) && !r_q.ack;
   assign idx      = i_avs_address[6:2];
   assign map_hit  = (i_avs_address[1:0] == 2'h0) && (idx >= `USRX_IDX_RCV_STAT) && (idx <= `USRX_IDX_INT_ENAB);
   assign do_read  = access && i_avs_read && map_hit;
   assign do_write = access && i_avs_write && map_hit && i_avs_byteenable[0];

   // register read mux
   always_comb
   begin
      rd_byte = 8'h00;
      case (idx)
         `USRX_IDX_RCV_STAT:
         begin
            rd_byte = {r_q.rcv_ctl[7:4], 1'b0, r_q.fifo0[9], r_q.overrun_error_flag, r_q.fifo0[8]}; // [RULE22] [RULE14] [RULE20]
         end
         `USRX_IDX_RCV_DATA:  rd_byte = r_q.fifo0[7:0];
         `USRX_IDX_XMT_STAT:
         begin
            rd_byte = `USRX_XMT_STAT_RST;
            rd_byte[`USRX_BIT_CLOCK_SOURCE_MASTER] = r_q.clock_source_master;
            rd_byte[`USRX_BIT_SYNC] = r_q.sync;
         end
         `USRX_IDX_INT_FLAGS:
         begin
            rd_byte = `USRX_INT_FLAGS_RST;                                // transmit empty always set
            rd_byte[`USRX_BIT_RECEIVE_COMPLETE_FLAG] = (r_q.count != 2'h0);               // [RULE7] [RULE9]
         end
         `USRX_IDX_BAUD_DIV:  rd_byte = r_q.baud;
         `USRX_IDX_INT_ENAB:  rd_byte = {7'h00, r_q.receive_interrupt_enable};
         default:             rd_byte = 8'h00;
      endcase
   end

   // frame end detection
   always_comb
   begin
      word_end  = 1'b0;
      word_framing_error_flag = 1'b0;
      if (r_q.sync)
      begin
         // sample on falling edge of driven clock, last data bit ends word
         word_end = active && tick && r_q.sclk && (r_q.st == USRX_DATA) && (r_q.bitn == last_bit); // [RULE2]
      end
      else if (active && tick && (r_q.st == USRX_STOP) && (r_q.ovs == `USRX_OVS_MID))
      begin
         word_end  = 1'b1;
         word_framing_error_flag = !i_rx_pin;                                          // [RULE23] [RULE20]
      end
   end

   // next state of all registers
   always_comb
   begin
      logic [8:0] w;
      w        = 9'h000;
      r_d      = r_q;
      r_d.ack  = 1'b0;
      r_d.irq  = r_q.receive_interrupt_enable && (r_q.count != 2'h0);                        // [RULE8]

      // bus access answered one cycle after it is seen
      if (access)
      begin
         r_d.ack   = 1'b1;
         r_d.resp  = map_hit ? 2'h0 : 2'h2;
         r_d.rdata = i_avs_read ? {24'h000000, rd_byte} : 32'h00000000;
      end
      if (do_write)
      begin
         case (idx)
            `USRX_IDX_RCV_STAT: r_d.rcv_ctl = {i_avs_writedata[7:4], 4'h0};
            `USRX_IDX_XMT_STAT:
            begin
               r_d.clock_source_master = i_avs_writedata[`USRX_BIT_CLOCK_SOURCE_MASTER];               // [RULE19]
               r_d.sync = i_avs_writedata[`USRX_BIT_SYNC];               // [RULE16]
            end
            `USRX_IDX_BAUD_DIV: r_d.baud = i_avs_writedata[7:0];         // [RULE21]
            `USRX_IDX_INT_ENAB: r_d.receive_interrupt_enable = i_avs_writedata[`USRX_BIT_RECEIVE_INTERRUPT_ENABLE];
            default:            r_d.baud = r_q.baud;
         endcase
      end

      // data read pops the fifo and brings next word's status
      if (do_read && (idx == `USRX_IDX_RCV_DATA) && (r_q.count != 2'h0))
      begin
         r_d.fifo0 = r_q.fifo1;                                          // [RULE14] [RULE10]
         r_d.count = r_q.count - 2'h1;                                   // [RULE9]
      end

      // baud generator reload
      r_d.brg = tick ? r_q.baud : r_q.brg - 8'h01;                       // [RULE21]

      // receive engine
      if (!active)
      begin
         r_d.st    = USRX_IDLE;                                          // [RULE15]
         r_d.sclk  = 1'b0;
         r_d.ovs   = 4'h0;
         r_d.bitn  = 4'h0;
         r_d.brg   = r_q.baud;
      end
      else if (tick)
      begin
         if (r_q.sync)
         begin
            case (r_q.st)
               USRX_IDLE:
               begin
                  r_d.st   = USRX_DATA;
                  r_d.bitn = 4'h0;
                  r_d.sclk = 1'b0;
               end
               USRX_DATA:
               begin
                  r_d.sclk = !r_q.sclk;                                  // [RULE24]
                  if (r_q.sclk)
                  begin
                     r_d.shift = {i_rx_pin, r_q.shift[8:1]};             // [RULE2]
                     r_d.bitn  = r_q.bitn + 4'h1;
                     if (r_q.bitn == last_bit)
                     begin
                        // continuous goes on, single word stops
                        r_d.st   = continuous_receive_enable ? USRX_DATA : USRX_DONE;         // [RULE3] [RULE4] [RULE5]
                        r_d.bitn = 4'h0;
                     end
                  end
               end
               USRX_DONE:
               begin
                  r_d.sclk = 1'b0;                                       // [RULE24]
                  if (continuous_receive_enable)
                  begin
                     r_d.st = USRX_DATA;
                  end
               end
               default: r_d.st = USRX_IDLE;
            endcase
         end
         else
         begin
            r_d.ovs = r_q.ovs + 4'h1;
            case (r_q.st)
               USRX_IDLE:
               begin
                  r_d.ovs = 4'h0;
                  if (!i_rx_pin)
                  begin
                     r_d.st = USRX_START;                                // [RULE23]
                  end
               end
               USRX_START:
               begin
                  if (r_q.ovs == `USRX_OVS_MID)
                  begin
                     r_d.st = i_rx_pin ? USRX_IDLE : USRX_START;         // glitch rejection
                  end
                  if (r_q.ovs == `USRX_OVS_LAST)
                  begin
                     r_d.st   = USRX_DATA;
                     r_d.bitn = 4'h0;
                  end
               end
               USRX_DATA:
               begin
                  if (r_q.ovs == `USRX_OVS_MID)
                  begin
                     r_d.shift = {i_rx_pin, r_q.shift[8:1]};             // [RULE23]
                  end
                  if (r_q.ovs == `USRX_OVS_LAST)
                  begin
                     r_d.bitn = r_q.bitn + 4'h1;
                     if (r_q.bitn == last_bit)
                     begin
                        r_d.st = USRX_STOP;
                     end
                  end
               end
               USRX_STOP:
               begin
                  if (r_q.ovs == `USRX_OVS_MID)
                  begin
                     r_d.st = USRX_IDLE;                                 // [RULE4] continuous by continuous_receive_enable
                  end
               end
               default: r_d.st = USRX_IDLE;
            endcase
         end
      end

      // word transfer into fifo, or overrun
      if (word_end)
      begin
         if (r_q.sync)
         begin
            w = {i_rx_pin, r_q.shift[8:1]};
         end
         else
         begin
            w = r_q.shift;
         end
         if (!nine)
         begin
            w = {1'b0, w[8:1]};                                          // 8 bit word is left aligned
         end
         if (r_q.overrun_error_flag)
         begin
            r_d.count = r_d.count;                                       // [RULE12]
         end
         else if (r_d.count == 2'h2)
         begin
            r_d.overrun_error_flag = 1'b1;                                             // [RULE11]
         end
         else if (r_d.count == 2'h1)
         begin
            r_d.fifo1 = {word_framing_error_flag, nine & w[8], w[7:0]};               // [RULE6] [RULE18]
            r_d.count = 2'h2;
         end
         else
         begin
            r_d.fifo0 = {word_framing_error_flag, nine & w[8], w[7:0]};               // [RULE6] [RULE10]
            r_d.count = 2'h1;                                            // [RULE7]
         end
      end

      // overrun clears with continuous enable or port enable low
      if (!r_q.rcv_ctl[`USRX_BIT_CONTINUOUS_RECEIVE_ENABLE] || !serial_port_enable)
      begin
         r_d.overrun_error_flag = 1'b0;                                                // [RULE13]
      end
   end

   // state register
   always_ff @(posedge i_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         r_q <= '{rcv_ctl: 8'h00, overrun_error_flag: 1'b0, clock_source_master: 1'b0, sync: 1'b0, baud: 8'h00, receive_interrupt_enable: 1'b0,
                  fifo0: 10'h000, fifo1: 10'h000, count: 2'h0, st: USRX_IDLE, brg: 8'h00,
                  ovs: 4'h0, bitn: 4'h0, shift: 9'h000, sclk: 1'b0, ack: 1'b0,
                  rdata: 32'h00000000, resp: 2'h0, irq: 1'b0};
      end
      else
      begin
         r_q <= r_d;
      end
   end

   // outputs from flip-flops, o_sclk_oen gated from three of them, data pin outputs constant
   assign o_avs_readdata    = r_q.rdata;
   assign o_avs_waitrequest = !r_q.ack;
   assign o_avs_response    = r_q.resp;
   assign o_rx_pin_out      = 1'b0;
   assign o_rx_pin_oen      = 1'b1;                                      // pin only received here
   assign o_sclk            = r_q.sclk;
   assign o_sclk_oen        = !(r_q.sync && r_q.clock_source_master && serial_port_enable);           // [RULE19]
   assign o_irq             = r_q.irq;                                   // [RULE8]
endmodule : usrx_receiver

// file: shared/usrx_defines.svh
// Purpose: constants for the serial receive block
// Assumes: included by bare name
// Notes:   offsets are register indexes, byte address is index times four
`ifndef USRX_DEFINES_SVH
`define USRX_DEFINES_SVH
`define USRX_IDX_RCV_STAT   5'h13
`define USRX_IDX_RCV_DATA   5'h14
`define USRX_IDX_XMT_STAT   5'h15
`define USRX_IDX_INT_FLAGS  5'h16
`define USRX_IDX_BAUD_DIV   5'h17
`define USRX_IDX_INT_ENAB   5'h18
`define USRX_BIT_SERIAL_PORT_ENABLE       7
`define USRX_BIT_NINE       6
`define USRX_BIT_SINGLE_RECEIVE_ENABLE       5
`define USRX_BIT_CONTINUOUS_RECEIVE_ENABLE       4
`define USRX_BIT_FRAMING_ERROR_FLAG       2
`define USRX_BIT_OVERRUN_ERROR_FLAG       1
`define USRX_BIT_D9         0
`define USRX_BIT_CLOCK_SOURCE_MASTER       7
`define USRX_BIT_SYNC       4
`define USRX_BIT_TRMT       1
`define USRX_BIT_RECEIVE_COMPLETE_FLAG       0
`define USRX_BIT_TRANSMIT_EMPTY_FLAG       1
`define USRX_BIT_RECEIVE_INTERRUPT_ENABLE       0
`define USRX_INT_FLAGS_RST  8'h02
`define USRX_XMT_STAT_RST   8'h02
`define USRX_OVS_MID        4'h7
`define USRX_OVS_LAST       4'hF
`define USRX_DATA_LAST8     4'h7
`define USRX_DATA_LAST9     4'h8
`endif

// file: shared/usrx_pkg.sv
// Purpose: types for the serial receive block
// Assumes: nothing
// Notes:   states gray coded along the async frame path
package usrx_pkg;
   typedef enum logic [2:0] {
      USRX_IDLE  = 3'h0,
      USRX_START = 3'h1,
      USRX_DATA  = 3'h3,
      USRX_STOP  = 3'h2,
      USRX_DONE  = 3'h6
   } usrx_state_e;
   typedef logic [9:0] usrx_word_t; // {framing, ninth, data[7:0]}
endpackage : usrx_pkg

// file: verif/usrx_serial_peer.sv
// Purpose: far-side serial partner, async transmitter or sync slave
// Assumes: sync slave shifts on rising serial clock, first rise is a dummy
// Notes:   line idles high async, toggles every cycle in sync idle
`timescale 1ns/1ps
module usrx_serial_peer
(
   input  wire logic       i_clk,
   input  wire logic       i_sclk,
   input  wire logic       i_sync,
   input  wire logic       i_go,
   input  wire logic [8:0] i_word,
   input  wire logic       i_nine,
   input  wire logic       i_stop,
   input  wire logic [7:0] i_bit_cyc,
   output logic            o_line,
   output logic            o_busy
);
   typedef struct packed {logic [11:0] sh; logic [3:0] n; logic [7:0] c; logic sclk;} usrx_peer_s;
   usrx_peer_s s_q = '0; // idle line, no frame pending
   usrx_peer_s s_d;
   // frame load and bit shifting
   always_comb
   begin
      s_d = s_q;
      s_d.sclk = i_sclk;
      s_d.c = s_q.c + 8'h01;
      if (i_go)
      begin
         s_d.sh = i_sync ? {2'h3, i_word, 1'b1} : i_nine ? {1'b1, i_stop, i_word, 1'b0}
                                                        : {2'h3, i_stop, i_word[7:0], 1'b0};
         s_d.n = i_sync ? (i_nine ? 4'hA : 4'h9) : 4'hC;
         s_d.c = 8'h00;
      end
      else if (s_q.n != 4'h0 && (i_sync ? (!s_q.sclk && i_sclk) : (s_q.c == i_bit_cyc)))
      begin
         s_d.sh = {1'b1, s_q.sh[11:1]}; // lsb first
         s_d.n = s_q.n - 4'h1;
         s_d.c = 8'h00;
      end
   end
   // state register
   always_ff @(posedge i_clk)
   begin
      s_q <= s_d;
   end
   assign o_busy = s_q.n != 4'h0;
   assign o_line = o_busy ? s_q.sh[0] : (i_sync ? s_q.c[0] : 1'b1);
endmodule : usrx_serial_peer

// file: verif/usrx_receiver_properties.sv
// Purpose: port-level checks of the serial receive block
// Assumes: one clock domain, reset active low
// Notes:   bound to every receiver instance
`timescale 1ns/1ps
module usrx_receiver_checker
(
   input  wire logic        i_clk,
   input  wire logic        i_resetn,
   input  wire logic [6:0]  i_avs_address,
   input  wire logic        i_avs_read,
   input  wire logic        i_avs_write,
   input  wire logic [31:0] o_avs_readdata,
   input  wire logic        o_avs_waitrequest,
   input  wire logic [1:0]  o_avs_response,
   input  wire logic        o_rx_pin_out,
   input  wire logic        o_rx_pin_oen,
   input  wire logic        o_sclk,
   input  wire logic        o_sclk_oen,
   input  wire logic        o_irq
);
   logic bad;
   logic pop;
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_resetn);
   // unmapped address, and data reads or any writes
   assign bad = i_avs_address[1:0] != 2'h0 || i_avs_address[6:2] < 5'h13 || i_avs_address[6:2] > 5'h18;
   assign pop = !o_avs_waitrequest && (i_avs_write || (i_avs_read && i_avs_address == 7'h50));
   AST_ACK_NEXT: assert property ((i_avs_read || i_avs_write) && o_avs_waitrequest |=> !o_avs_waitrequest)
      else $error("request not answered next cycle");
   AST_ACK_SINGLE: assert property (!o_avs_waitrequest |=> o_avs_waitrequest)
      else $error("waitrequest low too long");
   AST_BIT3_ZERO: assert property (
      !o_avs_waitrequest && i_avs_read && i_avs_address == 7'h4C |-> !o_avs_readdata[3])
      else $error("status bit 3 not zero");
   AST_UNMAPPED: assert property (!o_avs_waitrequest && i_avs_read && bad
      |-> o_avs_readdata == 32'h0 && o_avs_response == 2'h2) else $error("unmapped read wrong");
   AST_MAPPED: assert property (!o_avs_waitrequest && i_avs_read && !bad |-> o_avs_response == 2'h0)
      else $error("mapped read not ok");
   AST_SCLK_PARKED: assert property (o_sclk_oen && $past(o_sclk_oen) |-> !o_sclk)
      else $error("serial clock high while not driven");
   AST_PIN_INPUT: assert property (o_rx_pin_oen && !o_rx_pin_out)
      else $error("data pin driven");
   AST_IRQ_HOLD: assert property ($fell(o_irq) |-> $past(pop) || $past(pop, 2) || $past(pop, 3))
      else $error("request dropped without access");
endmodule : usrx_receiver_checker
bind usrx_receiver usrx_receiver_checker i_chk (.i_clk, .i_resetn, .i_avs_address, .i_avs_read,
   .i_avs_write, .o_avs_readdata, .o_avs_waitrequest, .o_avs_response, .o_rx_pin_out,
   .o_rx_pin_oen, .o_sclk, .o_sclk_oen, .o_irq);

// file: verif/tb_usrx_receiver.sv
// Purpose: self-checking bench for the serial receive block
// Assumes: bus answer within 20 cycles
// Notes:   async bit is 32 cycles, sync half period 4 cycles
`timescale 1ns/1ps
`include "usrx_defines.svh"
module tb_usrx_receiver;
   logic        i_clk = 1'b0;
   logic        i_resetn = 1'b0;
   logic [6:0]  i_avs_address = 7'h00;
   logic        i_avs_read = 1'b0;
   logic        i_avs_write = 1'b0;
   logic [31:0] i_avs_writedata = 32'h0;
   logic [31:0] o_avs_readdata;
   logic [1:0]  o_avs_response;
   logic        o_avs_waitrequest, o_rx_pin_out, o_rx_pin_oen, o_sclk, o_sclk_oen, o_irq;
   logic        i_rx_pin, busy, go = 1'b0, sync = 1'b0, nine = 1'b0, stop = 1'b1;
   logic [8:0]  word = 9'h000;
   logic [31:0] rd;
   logic [1:0]  resp;
   int          n_errors = 0;
   int          n_tests = 0;
   // 50 MHz clock
   always #10 i_clk = ~i_clk;
   usrx_receiver i_dut (.i_clk, .i_resetn, .i_avs_address, .i_avs_read, .i_avs_write, .i_avs_writedata,
      .i_avs_byteenable(4'hF), .o_avs_readdata, .o_avs_waitrequest, .o_avs_response, .i_rx_pin,
      .o_rx_pin_out, .o_rx_pin_oen, .o_sclk, .o_sclk_oen, .o_irq);
   usrx_serial_peer i_peer (.i_clk, .i_sclk(o_sclk), .i_sync(sync), .i_go(go), .i_word(word),
      .i_nine(nine), .i_stop(stop), .i_bit_cyc(8'h1F), .o_line(i_rx_pin), .o_busy(busy));
   task automatic end_sim;
      $display("checks %0d mismatches %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : end_sim
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         n_errors++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic bus(input logic wr, input logic [4:0] idx, input logic [7:0] wd);
      int k;
      @(posedge i_clk);
      i_avs_address <= {idx, 2'b00};
      i_avs_read <= !wr;
      i_avs_write <= wr;
      i_avs_writedata <= {24'h0, wd};
      k = 0;
      // look between edges, answer stands until the next rising edge
      @(negedge i_clk);
      while (o_avs_waitrequest !== 1'b0 && k < 20)
      begin
         @(negedge i_clk);
         k++;
      end
      if (k >= 20)
         n_errors++;
      rd = o_avs_readdata;
      resp = o_avs_response;
      @(posedge i_clk);
      i_avs_read <= 1'b0;
      i_avs_write <= 1'b0;
   endtask : bus
   task automatic rchk(input logic [4:0] idx, input logic [7:0] exp);
      bus(1'b0, idx, 8'h00);
      chk(rd, {24'h0, exp});
   endtask : rchk
   task automatic send(input logic [8:0] w, input logic s, input logic wt);
      int k;
      @(posedge i_clk);
      go <= 1'b1;
      word <= w;
      stop <= s;
      @(posedge i_clk);
      go <= 1'b0;
      k = 0;
      if (wt)
         do
         begin
            @(posedge i_clk);
            k++;
         end
         while (busy !== 1'b0 && k < 600);
      if (k >= 600)
         n_errors++;
   endtask : send
   task automatic t_regs;
      rchk(`USRX_IDX_INT_FLAGS, 8'h02);
      rchk(`USRX_IDX_INT_ENAB, 8'h00);
      bus(1'b0, `USRX_IDX_RCV_STAT, 8'h00);
      chk(rd & 32'hFFFF_FFFE, 32'h0);
      bus(1'b1, `USRX_IDX_INT_FLAGS, 8'hFF);
      rchk(`USRX_IDX_INT_FLAGS, 8'h02);
      rchk(5'h02, 8'h00);
      chk({30'h0, resp}, 32'h2);
      $display("test regs done");
   endtask : t_regs
   task automatic t_async;
      bus(1'b1, `USRX_IDX_BAUD_DIV, 8'h01);
      bus(1'b1, `USRX_IDX_XMT_STAT, 8'h00);
      bus(1'b1, `USRX_IDX_RCV_STAT, 8'h80);
      send(9'h05A, 1'b1, 1'b1);
      rchk(`USRX_IDX_INT_FLAGS, 8'h02);
      nine <= 1'b1;
      bus(1'b1, `USRX_IDX_RCV_STAT, 8'hD0);
      send(9'h1A5, 1'b0, 1'b1);
      send(9'h03C, 1'b1, 1'b1);
      rchk(`USRX_IDX_RCV_STAT, 8'hD5);
      rchk(`USRX_IDX_RCV_DATA, 8'hA5);
      rchk(`USRX_IDX_RCV_STAT, 8'hD0);
      rchk(`USRX_IDX_RCV_DATA, 8'h3C);
      rchk(`USRX_IDX_INT_FLAGS, 8'h02);
      $display("test async done");
   endtask : t_async
   task automatic t_overrun;
      nine <= 1'b0;
      bus(1'b1, `USRX_IDX_RCV_STAT, 8'h90);
      send(9'h011, 1'b1, 1'b1);
      chk({31'h0, o_irq}, 32'h0);
      bus(1'b1, `USRX_IDX_INT_ENAB, 8'h01);
      repeat (3) @(posedge i_clk);
      chk({31'h0, o_irq}, 32'h1);
      send(9'h022, 1'b1, 1'b1);
      send(9'h033, 1'b1, 1'b1);
      rchk(`USRX_IDX_RCV_STAT, 8'h92);
      rchk(`USRX_IDX_RCV_DATA, 8'h11);
      rchk(`USRX_IDX_RCV_DATA, 8'h22);
      send(9'h044, 1'b1, 1'b1);
      rchk(`USRX_IDX_INT_FLAGS, 8'h02);
      bus(1'b1, `USRX_IDX_RCV_STAT, 8'h80);
      rchk(`USRX_IDX_RCV_STAT, 8'h80);
      bus(1'b1, `USRX_IDX_INT_ENAB, 8'h00);
      $display("test overrun done");
   endtask : t_overrun
   task automatic t_sync;
      int k;
      sync <= 1'b1;
      bus(1'b1, `USRX_IDX_BAUD_DIV, 8'h03);
      bus(1'b1, `USRX_IDX_XMT_STAT, 8'h90);
      send(9'h0C6, 1'b1, 1'b0);
      bus(1'b1, `USRX_IDX_RCV_STAT, 8'hA0);
      k = 0;
      do
      begin
         bus(1'b0, `USRX_IDX_INT_FLAGS, 8'h00);
         k++;
      end
      while (rd[0] !== 1'b1 && k < 100);
      if (k >= 100)
         n_errors++;
      rchk(`USRX_IDX_RCV_DATA, 8'hC6);
      k = 0;
      repeat (64) @(posedge i_clk) k += int'(o_sclk === 1'b1);
      chk(k, 32'h0);
      bus(1'b1, `USRX_IDX_RCV_STAT, 8'hB0);
      k = 0;
      repeat (64) @(posedge i_clk) k += int'(o_sclk === 1'b1);
      chk({31'h0, k != 0}, 32'h1);
      bus(1'b1, `USRX_IDX_RCV_STAT, 8'h80);
      k = 0;
      repeat (64) @(posedge i_clk) k += int'(o_sclk === 1'b1);
      chk(k, 32'h0);
      $display("test sync done");
   endtask : t_sync
   // main sequence
   initial
   begin
      repeat (6) @(posedge i_clk);
      i_resetn <= 1'b1;
      t_regs;
      t_async;
      t_overrun;
      t_sync;
      end_sim;
   end
   // watchdog
   initial
   begin
      repeat (20000) @(posedge i_clk);
      n_errors++;
      end_sim;
   end
endmodule : tb_usrx_receiver
